// [rtl/pwr_rst_pkg.sv]
// Package: register map, field positions and reset values of the power
// configuration and reset control registers.
// Assumes a byte-wide register port fed by the serial control interface.
`default_nettype none
package pwr_rst_pkg;
  localparam logic [7:0] power_configuration_addr = 8'h0c;
  localparam logic [7:0] reset_control_addr = 8'h0e;
  localparam logic [7:0] power_configuration_reset = 8'h00;
  localparam logic [7:0] reset_control_reset = 8'h00;
  localparam logic [4:0] used_bits_mask = 5'h1f;
  // Power configuration fields
  localparam int pc_bias_gen_bit = 4;
  localparam int pc_ext_res_bit = 3;
  localparam int pc_sw_clamp_sel_bit = 2;
  localparam int pc_sw_clamp_on_bit = 1;
  localparam int pc_standby_bit = 0;
  // Reset control fields
  localparam int rc_analog_bit = 4;
  localparam int rc_post_conv_bit = 3;
  localparam int rc_sensor_if_bit = 2;
  localparam int rc_state_bit = 1;
  localparam int rc_soft_bit = 0;
  localparam logic [6:0] bias_ctrl_reset = 7'h00;
  localparam logic [6:0] bias_full_all = 7'h7f;
endpackage : pwr_rst_pkg
`default_nettype wire

// [rtl/reset_stretch.sv]
// Holds one block-reset output high while its cause is set.
// Assumes causes come from logic on mclk.
`default_nettype none
module reset_stretch (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic cause,
  output logic hold
);
  // Registered so the targeted block sees a clean, glitch-free reset
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      hold <= 1'b1;
    end else if (clk_en) begin
      hold <= cause;
    end
  end
endmodule : reset_stretch
`default_nettype wire

// [rtl/sensor_power_reset_control.sv]
// Power configuration and reset control registers of the sensor.
// Assumes the serial control interface delivers decoded byte writes and
// reads on mclk; the analog blocks consume the registered controls.
`default_nettype none
module sensor_power_reset_control
  import pwr_rst_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic init_pin,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] bias_ctrl_in,
  output logic [7:0] reg_rdata,
  output logic [6:0] bias_current_full,
  output logic use_external_bias_resistor,
  output logic bias_gen_active,
  output logic clamp_software_mode,
  output logic clamp_on,
  output logic soft_standby,
  output logic sensor_if_reset,
  output logic post_conv_reset,
  output logic converter_block_reset,
  output logic state_reset,
  output logic device_reset
);
  import pwr_rst_pkg::*;

  // ==========================================================
  // Pin synchroniser
  logic init_meta_reg;
  logic init_sync_reg;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      init_meta_reg <= 1'b0;
      init_sync_reg <= 1'b0;
    end else if (clk_en) begin
      init_meta_reg <= init_pin;
      init_sync_reg <= init_meta_reg;
    end
  end

  // ==========================================================
  // Registers
  logic [4:0] power_configuration_reg;
  logic [4:0] reset_control_reg;
  logic soft_reset_active;
  // Soft reset bit and init pin wipe the programmable power register too
  assign soft_reset_active = reset_control_reg[rc_soft_bit] |
                             init_sync_reg;

  // The reset register itself stays writable during soft reset, otherwise
  // the host could never release it.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      reset_control_reg <= reset_control_reset[4:0];
    end else if (clk_en) begin
      if (init_sync_reg) begin
        reset_control_reg <= reset_control_reset[4:0];
      end else if (reg_wr && reg_addr == reset_control_addr) begin
        // No self clearing: host writes 0 to leave reset
        reset_control_reg <= reg_wdata[4:0] & used_bits_mask;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      power_configuration_reg <= power_configuration_reset[4:0];
    end else if (clk_en) begin
      if (soft_reset_active) begin
        power_configuration_reg <= power_configuration_reset[4:0];
      end else if (reg_wr && reg_addr == power_configuration_addr) begin
        power_configuration_reg <= reg_wdata[4:0];
      end
    end
  end

  // Unused upper bits read as zero
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (clk_en && reg_rd) begin
      case (reg_addr)
        power_configuration_addr:
          reg_rdata <= {3'h0, power_configuration_reg};
        reset_control_addr:
          reg_rdata <= {3'h0, reset_control_reg};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Power controls
  logic bias_en;
  assign bias_en = power_configuration_reg[pc_bias_gen_bit];

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      bias_gen_active <= 1'b0;
    end else if (clk_en) begin
      bias_gen_active <= bias_en;
    end
  end

  // From the first enabled clock after reset, a disabled generator runs every block at resistor-set full current;
  // half settings are ignored until the generator is enabled again.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      bias_current_full <= bias_ctrl_reset;
    end else if (clk_en) begin
      if (bias_en) begin
        bias_current_full <= bias_ctrl_in;
      end else begin
        bias_current_full <= bias_full_all;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      use_external_bias_resistor <= 1'b0;
    end else if (clk_en) begin
      use_external_bias_resistor <=
        power_configuration_reg[pc_ext_res_bit];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      clamp_software_mode <= 1'b0;
    end else if (clk_en) begin
      clamp_software_mode <=
        power_configuration_reg[pc_sw_clamp_sel_bit];
    end
  end

  // Gated here so the clamp cannot fight the internal clamp source
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      clamp_on <= 1'b0;
    end else if (clk_en) begin
      clamp_on <= power_configuration_reg[pc_sw_clamp_sel_bit] &
                  power_configuration_reg[pc_sw_clamp_on_bit];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      soft_standby <= 1'b0;
    end else if (clk_en) begin
      soft_standby <= power_configuration_reg[pc_standby_bit];
    end
  end

  // ==========================================================
  // Block resets: soft reset covers every block, state reset every block but the device reset
  logic state_cause;
  logic sensor_if_cause;
  logic post_conv_cause;
  logic converter_cause;
  assign state_cause = reset_control_reg[rc_state_bit] |
                       soft_reset_active;
  assign sensor_if_cause = reset_control_reg[rc_sensor_if_bit] |
                           state_cause;
  assign post_conv_cause = reset_control_reg[rc_post_conv_bit] |
                           state_cause;
  assign converter_cause = reset_control_reg[rc_analog_bit] |
                           state_cause;

  // Each hold is a flop, so a block reset never glitches while the host
  // rewrites other bits of the reset register.
  reset_stretch u_sensor_if (
    .mclk(mclk),
    .rstn(rstn),
    .clk_en(clk_en),
    .cause(sensor_if_cause),
    .hold(sensor_if_reset)
  );

  reset_stretch u_post_conv (
    .mclk(mclk),
    .rstn(rstn),
    .clk_en(clk_en),
    .cause(post_conv_cause),
    .hold(post_conv_reset)
  );

  reset_stretch u_converter (
    .mclk(mclk),
    .rstn(rstn),
    .clk_en(clk_en),
    .cause(converter_cause),
    .hold(converter_block_reset)
  );

  // Held for as long as the cause stands; released one clock after it
  reset_stretch u_state (
    .mclk(mclk),
    .rstn(rstn),
    .clk_en(clk_en),
    .cause(state_cause),
    .hold(state_reset)
  );

  reset_stretch u_device (
    .mclk(mclk),
    .rstn(rstn),
    .clk_en(clk_en),
    .cause(soft_reset_active),
    .hold(device_reset)
  );
endmodule : sensor_power_reset_control
`default_nettype wire

// [bench/pwr_rst_chk_assertions.sv]
// Checker: port relations of the power and reset control block.
// Assumes it is bound to the block and that mclk is the only clock.
`default_nettype none
// ====================================================================
// Checker
module pwr_rst_chk (
  input wire logic mclk, rstn, clk_en, reg_wr, reg_rd,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire logic [6:0] bias_ctrl_in, bias_current_full,
  input wire logic bias_gen_active, clamp_software_mode, clamp_on,
  input wire logic sensor_if_reset, post_conv_reset, state_reset,
  input wire logic converter_block_reset
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic wr_rc;
  assign wr_rc = clk_en && reg_wr && reg_addr == 8'h0e;
  a_clamp_gated: assert property (clamp_on |-> clamp_software_mode)
    else $error("clamp on without software clamp select");
  a_sif_reset: assert property (
    wr_rc && reg_wdata[2] |-> ##2 sensor_if_reset)
    else $error("sensor interface reset late");
  a_post_reset: assert property (
    wr_rc && reg_wdata[3] |-> ##2 post_conv_reset)
    else $error("post conversion reset late");
  a_conv_reset: assert property (
    wr_rc && reg_wdata[4] |-> ##2 converter_block_reset)
    else $error("converter reset late");
  a_state_reset: assert property (
    wr_rc && reg_wdata[1] |-> ##2 state_reset)
    else $error("state reset late");
  // Two cycles of history keep the post-reset reload out of the check
  a_bias_fixed: assert property (
    !bias_gen_active && $past(rstn, 2) |-> bias_current_full == 7'h7f)
    else $error("bias not fixed while generator off");
  a_bias_follow: assert property (
    bias_gen_active && $past(rstn) |->
    bias_current_full == $past(bias_ctrl_in))
    else $error("bias does not follow per-block setting");
  a_unused_zero: assert property (
    clk_en && reg_rd |=> reg_rdata[7:5] == 3'h0)
    else $error("unused bits read nonzero");
  a_unmapped_zero: assert property (
    clk_en && reg_rd && reg_addr != 8'h0c && reg_addr != 8'h0e |=>
    reg_rdata == 8'h00)
    else $error("unmapped read nonzero");
  c_soft: cover property (wr_rc && reg_wdata[0]);
  c_clamp: cover property (clamp_on);
  c_follow: cover property (bias_gen_active);
endmodule : pwr_rst_chk
bind sensor_power_reset_control pwr_rst_chk i_pwr_rst_chk (.mclk, .rstn,
  .clk_en, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
  .bias_ctrl_in, .bias_current_full, .bias_gen_active,
  .clamp_software_mode, .clamp_on, .sensor_if_reset, .post_conv_reset,
  .state_reset, .converter_block_reset);
`default_nettype wire

// [bench/host_model.sv]
// Host model: byte writes and reads on the register port.
// Assumes the block samples requests at posedge mclk.
`default_nettype none
module host_model (
  input wire logic mclk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  // Data is taken one cycle after the request edge, once settled
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    #1 d = reg_rdata;
  endtask : rd
endmodule : host_model
`default_nettype wire

// [bench/sensor_power_reset_control_tb.sv]
// Testbench: register sequences with expected control outputs.
// Assumes host_model and the checker are compiled alongside.
`default_nettype none
module sensor_power_reset_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pwr_rst_pkg::*;
  logic mclk = 0, rstn = 0, gen, ext, swm, clon, stdby;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd;
  logic en = 1'b1, init = 1'b0;
  logic [6:0] bctl = 7'h2a;
  logic [6:0] full;
  logic [4:0] rv, e, m;
  int error_cnt = 0, check_count = 0, cyc = 0;
  always #50 mclk = ~mclk;
  host_model i_host_model (.mclk, .reg_rdata(rdata), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd));
  sensor_power_reset_control i_sensor_power_reset_control (.mclk, .rstn,
    .clk_en(en), .init_pin(init), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .bias_ctrl_in(bctl), .reg_rdata(rdata),
    .bias_current_full(full), .use_external_bias_resistor(ext),
    .bias_gen_active(gen), .clamp_software_mode(swm), .clamp_on(clon),
    .soft_standby(stdby), .sensor_if_reset(rv[2]),
    .post_conv_reset(rv[3]), .converter_block_reset(rv[4]),
    .state_reset(rv[1]), .device_reset(rv[0]));
  task check(string n, logic [7:0] s, logic [7:0] x);
    check_count++;
    if (s !== x) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask : check
  task end_of_test();
    if (error_cnt == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  task settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask : settle
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // ==================================================================
  // Sequence
  initial begin
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    settle();
    check("resets", rv, 5'h00);
    i_host_model.rd(power_configuration_addr, d);
    check("power", d, 8'h00);
    i_host_model.rd(reset_control_addr, d);
    check("reset", d, 8'h00);
    i_host_model.wr(power_configuration_addr, 8'hff);
    settle();
    check("ctl", {gen, ext, swm, clon, stdby}, 5'h1f);
    check("bias", full, 7'h2a);
    @(posedge mclk);
    bctl <= 7'h55;
    settle();
    check("bias", full, 7'h55);
    i_host_model.rd(power_configuration_addr, d);
    check("power", d, 8'h1f);
    i_host_model.wr(power_configuration_addr, 8'h02);
    settle();
    check("ctl", {gen, ext, swm, clon, stdby}, 5'h00);
    check("bias", full, 7'h7f);
    // A write while the clock enable is low must be lost
    @(posedge mclk);
    en <= 1'b0;
    i_host_model.wr(power_configuration_addr, 8'h1f);
    settle();
    check("frozen", {gen, ext, swm, clon, stdby}, 5'h00);
    @(posedge mclk);
    en <= 1'b1;
    settle();
    check("frozen", {gen, ext, swm, clon, stdby}, 5'h00);
    // Soft reset last: it clears the power register
    for (int i = 4; i >= 0; i--) begin
      i_host_model.wr(reset_control_addr, 8'h01 << i);
      settle();
      e = (5'h01 << i) | (i < 2 ? 5'h1e : 5'h00);
      m = 5'h1f;
      check("blocks", rv & m, e & m);
      i_host_model.rd(reset_control_addr, d);
      check("reset", d, 8'h01 << i);
      i_host_model.wr(power_configuration_addr, 8'h11);
      i_host_model.rd(power_configuration_addr, d);
      check("power", d, i == 0 ? 8'h00 : 8'h11);
      i_host_model.wr(reset_control_addr, 8'h00);
      settle();
      check("blocks", rv, 5'h00);
    end
    i_host_model.wr(power_configuration_addr, 8'h11);
    i_host_model.wr(reset_control_addr, 8'h04);
    @(posedge mclk);
    init <= 1'b1;
    settle();
    check("init", rv, 5'h1f);
    @(posedge mclk);
    init <= 1'b0;
    settle();
    check("init", rv, 5'h00);
    i_host_model.rd(power_configuration_addr, d);
    check("power", d, 8'h00);
    i_host_model.rd(reset_control_addr, d);
    check("reset", d, 8'h00);
    // Second reset in mid-run
    i_host_model.wr(power_configuration_addr, 8'h11);
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    check("rst", rv, 5'h1f);
    @(posedge mclk);
    rstn <= 1'b1;
    settle();
    check("rst", rv, 5'h00);
    i_host_model.rd(power_configuration_addr, d);
    check("power", d, 8'h00);
    i_host_model.wr(8'h0d, 8'hff);
    i_host_model.rd(8'h0d, d);
    check("unmapped", d, 8'h00);
    end_of_test();
  end
endmodule : sensor_power_reset_control_tb
`default_nettype wire
